/* File: lvd_ctrl.sv */
// lvd_ctrl: control and sequencing of a supply low-voltage detector.
// assumes an asynchronous comparator level (1 = supply below threshold) and an
// external reset controller that pulses i_rst and reports whether the reset
// it issued was caused by o_det_reset (i_rst_was_det, read on clock edges during reset and at the first edge after release).
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
module lvd_ctrl (
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst,
    input  wire logic             i_rst_was_det,
    input  wire logic             i_cmp_below,
    input  wire lvd_pkg::lvd_bus_t i_bus,
    output logic [7:0]            o_rdata,
    output logic [3:0]            o_level_sel,
    output logic                  o_cmp_enable,
    output logic                  o_det_reset,
    output logic                  o_detect_irq,
    output logic                  o_settled
);
    logic       sync1_reg;
    logic       sync2_reg;
    logic       below_d_reg;
    logic       detect_enable_reg;
    logic       detect_mode_reset_sel_reg;
    logic [3:0] detect_level_select_reg;
    logic       detect_irq_mask_reg;
    logic       detect_irq_request_flag_reg;
    logic       detect_reset_source_flag_reg;
    logic       capt_done_reg;
    logic [15:0] settle_cnt_reg;
    logic       irq_event;
    logic       wr_ctrl;
    logic       below_live;
    logic [7:0] rdata_next;

    // only the second stage is read by logic
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= i_cmp_below;
            sync2_reg <= sync1_reg;
        end
    end

    assign below_live = detect_enable_reg & sync2_reg;
    assign wr_ctrl    = i_bus.wr && (i_bus.addr == lvd_pkg::ADDR_CTRL);

    // no async reset here: these must survive a detector reset, so they are
    // cleared on clock edges only while the cause input reports an ordinary
    // reset, up to the first edge after release, and held through the rest
    always_ff @(posedge i_clk_sys) begin
        if (!capt_done_reg && !i_rst_was_det) begin
            detect_enable_reg         <= 1'b0;
            detect_mode_reset_sel_reg <= 1'b0;
            detect_level_select_reg   <= lvd_pkg::LEVEL_RESET;
        end else if (i_rst) begin
            detect_enable_reg         <= detect_enable_reg;
        end else if (wr_ctrl) begin
            detect_enable_reg         <= i_bus.wdata[lvd_pkg::BIT_ENABLE];
            detect_mode_reset_sel_reg <= i_bus.wdata[lvd_pkg::BIT_MODE];
        end else if (i_bus.wr && i_bus.addr == lvd_pkg::ADDR_LEVEL) begin
            detect_level_select_reg   <= i_bus.wdata[lvd_pkg::LEVEL_W-1:0];
        end
    end

    // capture of reset cause happens once, right after release
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            capt_done_reg                <= 1'b0;
            detect_reset_source_flag_reg <= 1'b0;
        end else if (!capt_done_reg) begin
            capt_done_reg                <= 1'b1;
            detect_reset_source_flag_reg <= i_rst_was_det;
        end else if (i_bus.rd && i_bus.addr == lvd_pkg::ADDR_RESCAUS) begin
            // read clears, as reset cause registers usually do
            detect_reset_source_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            detect_irq_mask_reg <= 1'b1;
        end else if (i_bus.wr && i_bus.addr == lvd_pkg::ADDR_MASK) begin
            detect_irq_mask_reg <= i_bus.wdata[lvd_pkg::BIT_MASK];
        end
    end

    // crossings in either direction while enabled in interrupt mode, plus
    // the rise or drop of the flag when the detector is switched on or off while below
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            below_d_reg <= 1'b0;
        end else begin
            below_d_reg <= below_live;
        end
    end
    assign irq_event = (below_live != below_d_reg) && !detect_mode_reset_sel_reg;

    // set wins over a software clear in the same cycle
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            detect_irq_request_flag_reg <= 1'b0;
        end else if (irq_event) begin
            detect_irq_request_flag_reg <= 1'b1;
        end else if (i_bus.wr && i_bus.addr == lvd_pkg::ADDR_IRQREQ) begin
            detect_irq_request_flag_reg <= i_bus.wdata[lvd_pkg::BIT_IRQREQ];
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_detect_irq <= 1'b0;
        end else begin
            // an unmasked request shows one cycle later, even right after enable
            o_detect_irq <= detect_irq_request_flag_reg & ~detect_irq_mask_reg;
        end
    end

    // reset request follows the live level only, so setting the mode while
    // supply is good raises nothing
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_det_reset <= 1'b0;
        end else begin
            o_det_reset <= detect_mode_reset_sel_reg & below_live;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            settle_cnt_reg <= '0;
            o_settled      <= 1'b0;
        end else if (!detect_enable_reg) begin
            settle_cnt_reg <= '0;
            o_settled      <= 1'b0;
        end else if (settle_cnt_reg != 16'(lvd_pkg::SETTLE_CYC)) begin
            settle_cnt_reg <= settle_cnt_reg + 16'h0001;
        end else begin
            o_settled      <= 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_level_sel  <= lvd_pkg::LEVEL_RESET;
            o_cmp_enable <= 1'b0;
        end else begin
            o_level_sel  <= detect_level_select_reg;
            o_cmp_enable <= detect_enable_reg;
        end
    end

    always_comb begin
        rdata_next = 8'h00;
        unique case (i_bus.addr)
            lvd_pkg::ADDR_CTRL: begin
                rdata_next[lvd_pkg::BIT_ENABLE] = detect_enable_reg;
                rdata_next[lvd_pkg::BIT_MODE]   = detect_mode_reset_sel_reg;
                rdata_next[lvd_pkg::BIT_FLAG]   = below_live;
            end
            lvd_pkg::ADDR_LEVEL:   rdata_next[3:0] = detect_level_select_reg;
            lvd_pkg::ADDR_IRQREQ:  rdata_next[lvd_pkg::BIT_IRQREQ] = detect_irq_request_flag_reg;
            lvd_pkg::ADDR_MASK:    rdata_next[lvd_pkg::BIT_MASK] = detect_irq_mask_reg;
            lvd_pkg::ADDR_RESCAUS: rdata_next[lvd_pkg::BIT_RSTSRC] = detect_reset_source_flag_reg;
            default:               rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
        end else if (i_bus.rd) begin
            o_rdata <= rdata_next;
        end else begin
            o_rdata <= 8'h00;
        end
    end

    a_reset_follows_level: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_det_reset == $past(detect_mode_reset_sel_reg & below_live))
        else $error("detector reset does not follow level");
    a_no_reset_when_ok: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !below_live |=> !o_det_reset)
        else $error("reset raised while supply good");
    a_flag_zero_off: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !detect_enable_reg |-> !rdata_next[0] || i_bus.addr != lvd_pkg::ADDR_CTRL)
        else $error("flag set while disabled");
    a_irq_both_edges: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        irq_event |=> detect_irq_request_flag_reg)
        else $error("crossing lost");
    a_irq_unmasked: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        detect_irq_request_flag_reg && !detect_irq_mask_reg |=> o_detect_irq)
        else $error("unmasked request not shown");
    a_mask_after_reset: assert property (@(posedge i_clk_sys)
        $fell(i_rst) |-> detect_irq_mask_reg)
        else $error("mask not set by reset");
    a_req_clearable: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_bus.wr && i_bus.addr == lvd_pkg::ADDR_IRQREQ && !i_bus.wdata[1] && !irq_event
        |=> !detect_irq_request_flag_reg)
        else $error("request flag not cleared");
    a_cause_logged: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !capt_done_reg |=> detect_reset_source_flag_reg == $past(i_rst_was_det))
        else $error("reset cause not recorded");
    a_sync_delay: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        sync2_reg == $past(i_cmp_below, 2) || $past(i_rst, 2))
        else $error("comparator not synchronised");
    a_off_irq: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        below_d_reg && !below_live && !detect_mode_reset_sel_reg
        |=> detect_irq_request_flag_reg)
        else $error("disable while below gave no request");
endmodule

/* File: lvd_ctrl_tb.sv */
// lvd_ctrl_tb: self-checking bench for the low-voltage detect control block.
// assumes lvd_pkg is compiled first; the bench plays the cpu, the comparator
// and the reset controller itself.
`timescale 1ns/100ps
module lvd_ctrl_tb;
    logic              i_clk_sys;
    logic              i_rst;
    logic              i_rst_was_det;
    logic              i_cmp_below;
    lvd_pkg::lvd_bus_t i_bus;
    logic [7:0]        o_rdata;
    logic [3:0]        o_level_sel;
    logic              o_cmp_enable;
    logic              o_det_reset;
    logic              o_detect_irq;
    logic              o_settled;
    int                err_count;
    int                num_checks;
    logic [7:0]        rv;

    lvd_ctrl i_lvd_ctrl (
        .i_clk_sys     (i_clk_sys),
        .i_rst         (i_rst),
        .i_rst_was_det (i_rst_was_det),
        .i_cmp_below   (i_cmp_below),
        .i_bus         (i_bus),
        .o_rdata       (o_rdata),
        .o_level_sel   (o_level_sel),
        .o_cmp_enable  (o_cmp_enable),
        .o_det_reset   (o_det_reset),
        .o_detect_irq  (o_detect_irq),
        .o_settled     (o_settled)
    );

    initial i_clk_sys = 1'b0;
    always #50 i_clk_sys = ~i_clk_sys;

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (err_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk_sys);
        i_bus.wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so sample there
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge i_clk_sys);
        i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk_sys);
        i_bus.rd <= 1'b0;
        #1 d = o_rdata;
    endtask

    // bounded wait; sel 0 watches o_settled, sel 1 watches o_det_reset
    task automatic wait_bit(input int sel, input logic v, input int bound);
        int n;
        n = 0;
        while (((sel == 0) ? o_settled : o_det_reset) !== v) begin
            if (n == bound) begin
                chk(8'h00, 8'h01);
                tally_and_finish();
            end
            n++;
            @(posedge i_clk_sys);
            #1;
        end
    endtask

    // the external reset controller: level pulse, cause valid at release
    task automatic do_reset(input logic was_det);
        @(posedge i_clk_sys);
        i_rst         <= 1'b1;
        i_rst_was_det <= was_det;
        repeat (6) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
    endtask

    initial begin
        err_count = 0;
        num_checks = 0;
        i_rst = 1'b1;
        i_rst_was_det = 1'b0;
        i_cmp_below = 1'b0;
        i_bus = '{addr: 3'h0, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
        do_reset(1'b0);
        rd(lvd_pkg::ADDR_CTRL, rv);
        chk(rv, 8'h00);
        rd(lvd_pkg::ADDR_MASK, rv);
        chk(rv, 8'h01);
        // interrupt mode start-up: mask, level, mode 0, enable, wait
        wr(lvd_pkg::ADDR_MASK, 8'h01);
        wr(lvd_pkg::ADDR_LEVEL, 8'h0A);
        rd(lvd_pkg::ADDR_LEVEL, rv);
        chk(rv, 8'h0A);
        chk({4'h0, o_level_sel}, 8'h0A);
        wr(lvd_pkg::ADDR_CTRL, 8'h80);
        repeat (2000) @(posedge i_clk_sys);
        #1 chk({7'h00, o_settled}, 8'h00);
        wait_bit(0, 1'b1, 200);
        chk({7'h00, o_cmp_enable}, 8'h01);
        rd(lvd_pkg::ADDR_CTRL, rv);
        chk(rv, 8'h80);
        wr(lvd_pkg::ADDR_IRQREQ, 8'h00);
        // falling supply while still masked: request only, no interrupt
        i_cmp_below <= 1'b1;
        repeat (6) @(posedge i_clk_sys);
        rd(lvd_pkg::ADDR_CTRL, rv);
        chk(rv, 8'h81);
        rd(lvd_pkg::ADDR_IRQREQ, rv);
        chk(rv, 8'h02);
        chk({7'h00, o_detect_irq}, 8'h00);
        wr(lvd_pkg::ADDR_MASK, 8'h00);
        repeat (2) @(posedge i_clk_sys);
        #1 chk({7'h00, o_detect_irq}, 8'h01);
        wr(lvd_pkg::ADDR_IRQREQ, 8'h00);
        rd(lvd_pkg::ADDR_IRQREQ, rv);
        chk(rv, 8'h00);
        i_cmp_below <= 1'b0;
        repeat (6) @(posedge i_clk_sys);
        rd(lvd_pkg::ADDR_IRQREQ, rv);
        chk(rv, 8'h02);
        // stop while below: the flag falls and raises a request
        wr(lvd_pkg::ADDR_IRQREQ, 8'h00);
        i_cmp_below <= 1'b1;
        repeat (6) @(posedge i_clk_sys);
        wr(lvd_pkg::ADDR_IRQREQ, 8'h00);
        wr(lvd_pkg::ADDR_CTRL, 8'h00);
        repeat (4) @(posedge i_clk_sys);
        rd(lvd_pkg::ADDR_IRQREQ, rv);
        chk(rv, 8'h02);
        rd(lvd_pkg::ADDR_CTRL, rv);
        chk(rv, 8'h00);
        wr(lvd_pkg::ADDR_IRQREQ, 8'h00);
        // reset mode start-up: mode is set only once the flag shows supply ok
        i_cmp_below <= 1'b0;
        wr(lvd_pkg::ADDR_MASK, 8'h01);
        wr(lvd_pkg::ADDR_CTRL, 8'h80);
        wait_bit(0, 1'b1, 2200);
        rd(lvd_pkg::ADDR_CTRL, rv);
        chk(rv, 8'h80);
        wr(lvd_pkg::ADDR_CTRL, 8'h82);
        repeat (6) @(posedge i_clk_sys);
        #1 chk({7'h00, o_det_reset}, 8'h00);
        i_cmp_below <= 1'b1;
        wait_bit(1, 1'b1, 10);
        i_cmp_below <= 1'b0;
        wait_bit(1, 1'b0, 10);
        i_cmp_below <= 1'b1;
        wait_bit(1, 1'b1, 10);
        i_cmp_below <= 1'b0;
        do_reset(1'b1);
        // a shortened fluctuation wait keeps the run small
        repeat (500) @(posedge i_clk_sys);
        rd(lvd_pkg::ADDR_CTRL, rv);
        chk(rv, 8'h82);
        rd(lvd_pkg::ADDR_LEVEL, rv);
        chk(rv, 8'h0A);
        rd(lvd_pkg::ADDR_MASK, rv);
        chk(rv, 8'h01);
        rd(lvd_pkg::ADDR_RESCAUS, rv);
        chk(rv, 8'h01);
        rd(lvd_pkg::ADDR_RESCAUS, rv);
        chk(rv, 8'h00);
        wr(3'h7, 8'hFF);
        rd(3'h7, rv);
        chk(rv, 8'h00);
        // ordered stop, then an ordinary reset clears the controls
        wr(lvd_pkg::ADDR_CTRL, 8'h80);
        wr(lvd_pkg::ADDR_CTRL, 8'h00);
        rd(lvd_pkg::ADDR_CTRL, rv);
        chk(rv, 8'h00);
        wr(lvd_pkg::ADDR_CTRL, 8'h82);
        do_reset(1'b0);
        rd(lvd_pkg::ADDR_CTRL, rv);
        chk(rv, 8'h00);
        rd(lvd_pkg::ADDR_RESCAUS, rv);
        chk(rv, 8'h00);
        tally_and_finish();
    end
endmodule

/* File: lvd_pkg.sv */
// lvd_pkg: register map, field positions, reset values and timing for the
// low-voltage detect control block; assumes a 10 MHz system clock.
package lvd_pkg;
    localparam logic [2:0] ADDR_CTRL    = 3'h0;
    localparam logic [2:0] ADDR_LEVEL   = 3'h1;
    localparam logic [2:0] ADDR_IRQREQ  = 3'h2;
    localparam logic [2:0] ADDR_MASK    = 3'h3;
    localparam logic [2:0] ADDR_RESCAUS = 3'h4;
    localparam int         BIT_ENABLE   = 7;
    localparam int         BIT_MODE     = 1;
    localparam int         BIT_FLAG     = 0;
    localparam int         BIT_IRQREQ   = 1;
    localparam int         BIT_MASK     = 0;
    localparam int         BIT_RSTSRC   = 0;
    localparam int         LEVEL_W      = 4;
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [3:0] LEVEL_RESET  = 4'h0;
    localparam int         CLK_HZ       = 10_000_000;
    localparam int         SETTLE_US    = 210;
    localparam int         SETTLE_CYC   = (SETTLE_US * (CLK_HZ / 1_000_000));

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } lvd_bus_t;
endpackage
